// [common/velocity_objects_pkg.sv]
// Package for the velocity-mode object dictionary block: object indices,
// sub-indices, value limits, masks, values after reset and the state type.
// Assumes one system clock domain; all figures here are shared by design and bench.
package velocity_objects_pkg;

  // Object indices
  localparam logic [15:0] IDX_COMMAND_WORD  = 16'h6040;
  localparam logic [15:0] IDX_STATE_WORD    = 16'h6041;
  localparam logic [15:0] IDX_SPEED_REF     = 16'h6042;
  localparam logic [15:0] IDX_RAMP_OUTPUT   = 16'h6043;
  localparam logic [15:0] IDX_ACTUAL_SPEED  = 16'h6044;
  localparam logic [15:0] IDX_SPEED_LIMITS  = 16'h6046;
  localparam logic [15:0] IDX_ACCEL         = 16'h6048;
  localparam logic [15:0] IDX_DECEL         = 16'h6049;

  // Sub-indices
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ONE   = 8'h01;
  localparam logic [7:0] SUB_TWO   = 8'h02;
  localparam logic [7:0] ENTRY_COUNT = 8'h02;   // Highest sub-entry of each multi-entry object

  // Control source value that hands the state machine to the fieldbus
  localparam logic [15:0] CTRL_SRC_REMOTE = 16'h0001;

  // Command word: bits 4..6 and 8 only in motion control; 9..15 never
  localparam logic [15:0] CMD_MOTION_BITS = 16'h0170;
  localparam logic [15:0] CMD_USED_BITS   = 16'h01FF;
  // State word: bits 8 and 14 unused; 12,13 only in motion control
  localparam logic [15:0] STAT_MOTION_BITS = 16'h3000;
  localparam logic [15:0] STAT_UNUSED_BITS = 16'h4100;

  // Value ranges
  localparam logic [31:0] RPM_MAX       = 32'h0000_7FFF;
  localparam logic [31:0] STEP_MIN      = 32'h0000_0001;
  localparam logic [31:0] TIME_MAX      = 32'h0000_FFFF;

  // Frequency is carried in 1/100 Hz; conversion divides by sixty
  localparam int FREQ_SCALE   = 100;
  localparam int SECS_PER_MIN = 60;

  // Values after reset
  localparam logic [15:0] RST_MIN_RPM   = 16'h0000;
  localparam logic [15:0] RST_MAX_RPM   = 16'h7FFF;
  localparam logic [15:0] RST_STEP_RPM  = 16'h05DC;
  localparam logic [15:0] RST_STEP_TIME = 16'h0005;

  // Whole state of the block
  typedef struct packed {
    logic [15:0]        cmdWord;
    logic signed [15:0] speedRef;
    logic [15:0]        minRpm;
    logic [15:0]        maxRpm;
    logic [15:0]        accSpeed;
    logic [15:0]        accTime;
    logic [15:0]        decSpeed;
    logic [15:0]        decTime;
    logic [31:0]        minFreq;
    logic [31:0]        maxFreq;
    logic [31:0]        accGrad;
    logic [31:0]        decGrad;
    logic signed [31:0] rampInFreq;
    logic [15:0]        cmdOut;
    logic [31:0]        rdData;
    logic               ack;
    logic               abort;
    logic               dirty;
    logic               nvStore;
  } obj_state_t;

endpackage

// [logic/velocity_objects.sv]
// Velocity-mode object dictionary of the drive: command and state words,
// speed reference with clamping, readbacks, speed limits and ramp gradients.
// Assumes the fieldbus stack delivers object accesses as one-cycle strobes on
// clk_sys, and that a non-volatile store outside takes and returns saved values.
//
// Overview of operation
// - Command word acts only under remote control source
// - Ignore bits 9-15; 4-6,8 motion only
// - State word: 8,14 unused; 12,13 motion only
// - Speed reference signed, -32768 to 32767 rpm
// - Reference frequency uses active pole-pair count
// - Converted reference added to channel at ramp
// - Motion control uses data set one poles
// - Ramp output readback in rpm, active poles
// - Actual speed readback in rpm, active poles
// - Sub-entry zero reports count of two
// - Limits unsigned, 0 to 32767, set-one poles
// - Minimum write mirrors minimum frequency parameter
// - Maximum write mirrors maximum frequency parameter
// - Reference clamped between minimum and maximum
// - Save stores limits and accel ramp; restore overrides
// - Accel step 1-32767 rpm, time 1-65535 s
// - Accel gradient to both direction parameters
// - Gradients use set-one poles, recomputed every clock
// - Decel object shares accel layout and limits
// - Decel gradient to both direction parameters
`timescale 1ns/100ps
`default_nettype none

module velocity_objects
  import velocity_objects_pkg::*;
(
  input  wire logic               clk_sys,            // 20 MHz system clock
  input  wire logic               rst,                // Asynchronous, active high
  input  wire logic               clkEn,              // Freezes all state while low
  input  wire logic               objWrite,           // Object write strobe
  input  wire logic               objRead,            // Object read strobe
  input  wire logic [15:0]        objIndex,           // Object index
  input  wire logic [7:0]         objSub,             // Sub-index
  input  wire logic [31:0]        objWrData,          // Write data
  output logic [31:0]             objRdData,          // Read data, registered
  output logic                    objAck,             // Access accepted, pulse
  output logic                    objAbort,           // Access refused, pulse
  input  wire logic [15:0]        control_source_select, // Control source parameter
  input  wire logic               motionConfig,       // Motion control configuration active
  input  wire logic [7:0]         polePairsActive,    // Pole pairs of active data set
  input  wire logic [7:0]         polePairsSetOne,    // Pole pairs of data set one
  input  wire logic [15:0]        driveState,         // Raw drive state bits
  input  wire logic signed [31:0] channelRefFreq,     // Frequency reference channel value
  input  wire logic signed [31:0] rampOutFreq,        // Ramp function output frequency
  input  wire logic signed [31:0] actualFreq,         // Actual drive frequency
  output logic [15:0]             stateMachineCmd,    // Filtered command to state machine
  output logic signed [31:0]      rampInputFreq,      // Sum at ramp function input
  output logic [31:0]             minFreqParam,       // Minimum frequency, all data sets
  output logic [31:0]             maxFreqParam,       // Maximum frequency, all data sets
  output logic [31:0]             accelCwParam,       // Acceleration clockwise
  output logic [31:0]             accelAcwParam,      // Acceleration anticlockwise
  output logic [31:0]             decelCwParam,       // Deceleration clockwise
  output logic [31:0]             decelAcwParam,      // Deceleration anticlockwise
  input  wire logic               saveCmd,            // Parameter-save command, pulse
  output logic                    nvStore,            // Store request to NV memory, pulse
  output logic [63:0]             nvData,             // Limits and acceleration ramp for NV memory
  input  wire logic               nvLoad,             // Restored values valid, pulse
  input  wire logic [63:0]        nvLoadData          // Values restored at power-on
);

  obj_state_t stateReg;   // Registered state
  obj_state_t stateNext;  // Next state

  // Pole count for reference conversion: set one in motion control
  logic [7:0] refPoles;
  assign refPoles = motionConfig ? polePairsSetOne : polePairsActive;

  // Rpm to 1/100 Hz: rpm * poles / 60, scaled
  function automatic logic signed [31:0] rpmToFreq(input logic signed [16:0] rpm,
                                                   input logic [7:0] poles);
    logic signed [31:0] prod;
    prod = 32'(rpm) * $signed({24'h000000, poles}) * FREQ_SCALE;
    return prod / SECS_PER_MIN;
  endfunction

  // 1/100 Hz back to rpm; zero poles reads as zero rather than dividing by zero
  function automatic logic signed [15:0] freqToRpm(input logic signed [31:0] freq,
                                                   input logic [7:0] poles);
    logic signed [31:0] den;
    logic signed [31:0] res;
    den = $signed({24'h000000, poles}) * FREQ_SCALE;
    res = (poles == 8'h00) ? 32'sh0 : (freq * SECS_PER_MIN) / den;
    return res[15:0];
  endfunction

  // Gradient in 1/100 Hz per second from a speed step and a time step
  function automatic logic [31:0] gradient(input logic [15:0] step, input logic [15:0] secs,
                                           input logic [7:0] poles);
    logic [47:0] num;
    logic [47:0] den;
    logic [47:0] q;
    num = 48'(step) * 48'(poles) * 48'(FREQ_SCALE);
    den = 48'(secs) * 48'(SECS_PER_MIN);
    q   = (secs == 16'h0000) ? 48'h0 : num / den;
    return q[31:0];
  endfunction

  // Range checks for incoming values
  logic wrRpmOk;    // 0..32767
  logic wrStepOk;   // 1..32767
  logic wrTimeOk;   // 1..65535
  logic wrSpeedOk;  // Fits a signed 16-bit value
  assign wrRpmOk   = objWrData <= RPM_MAX;
  assign wrStepOk  = objWrData >= STEP_MIN && objWrData <= RPM_MAX;
  assign wrTimeOk  = objWrData >= STEP_MIN && objWrData <= TIME_MAX;
  assign wrSpeedOk = objWrData[31:15] == {17{objWrData[15]}};

  // Clamped speed reference
  logic signed [16:0] clampedRpm;
  always_comb begin
    clampedRpm = 17'(stateReg.speedRef);
    // Limits are non-negative, so a reverse reference is raised to the minimum
    if (clampedRpm < $signed({1'b0, stateReg.minRpm})) begin
      clampedRpm = $signed({1'b0, stateReg.minRpm});
    end else if (clampedRpm > $signed({1'b0, stateReg.maxRpm})) begin
      clampedRpm = $signed({1'b0, stateReg.maxRpm});
    end
  end

  // Masked state word as software sees it
  logic [15:0] stateWordView;
  always_comb begin
    stateWordView = driveState & ~STAT_UNUSED_BITS;
    if (!motionConfig) begin
      stateWordView = stateWordView & ~STAT_MOTION_BITS;
    end
  end

  // Next-state logic: accesses, mirroring, save and restore
  always_comb begin
    stateNext         = stateReg;
    stateNext.ack     = 1'b0;
    stateNext.abort   = 1'b0;
    stateNext.nvStore = 1'b0;
    // Reference into the ramp: converted, then added to the channel value
    stateNext.rampInFreq = rpmToFreq(clampedRpm, refPoles) + channelRefFreq;
    // Command word passes to the state machine only under remote control
    if (control_source_select == CTRL_SRC_REMOTE) begin
      stateNext.cmdOut = stateReg.cmdWord & CMD_USED_BITS;
      if (!motionConfig) begin
        stateNext.cmdOut = stateNext.cmdOut & ~CMD_MOTION_BITS;
      end
    end else begin
      stateNext.cmdOut = 16'h0000;
    end
    if (objWrite) begin
      // Writes; an out-of-range value or read-only entry is refused untouched
      stateNext.ack = 1'b1;
      case (objIndex)
        IDX_COMMAND_WORD: begin
          if (objSub == SUB_COUNT && objWrData[31:16] == 16'h0000) begin
            stateNext.cmdWord = objWrData[15:0];
          end else begin
            stateNext.abort = 1'b1;
          end
        end
        IDX_SPEED_REF: begin
          // A motor change takes effect on the next clock, without writing this again
          if (objSub == SUB_COUNT && wrSpeedOk) begin
            stateNext.speedRef = $signed(objWrData[15:0]);
          end else begin
            stateNext.abort = 1'b1;
          end
        end
        IDX_SPEED_LIMITS: begin
          if (objSub == SUB_ONE && wrRpmOk) begin
            stateNext.minRpm  = objWrData[15:0];
            stateNext.minFreq = 32'(rpmToFreq({1'b0, objWrData[15:0]}, polePairsSetOne));
            stateNext.dirty   = 1'b1;
          end else if (objSub == SUB_TWO && wrRpmOk) begin
            stateNext.maxRpm  = objWrData[15:0];
            stateNext.maxFreq = 32'(rpmToFreq({1'b0, objWrData[15:0]}, polePairsSetOne));
            stateNext.dirty   = 1'b1;
          end else begin
            stateNext.abort = 1'b1;
          end
        end
        IDX_ACCEL: begin
          if (objSub == SUB_ONE && wrStepOk) begin
            stateNext.accSpeed = objWrData[15:0];
            stateNext.dirty    = 1'b1;
          end else if (objSub == SUB_TWO && wrTimeOk) begin
            stateNext.accTime = objWrData[15:0];
            stateNext.dirty   = 1'b1;
          end else begin
            stateNext.abort = 1'b1;
          end
        end
        IDX_DECEL: begin
          if (objSub == SUB_ONE && wrStepOk) begin
            stateNext.decSpeed = objWrData[15:0];
            stateNext.dirty    = 1'b1;
          end else if (objSub == SUB_TWO && wrTimeOk) begin
            stateNext.decTime = objWrData[15:0];
            stateNext.dirty   = 1'b1;
          end else begin
            stateNext.abort = 1'b1;
          end
        end
        default: begin
          // Read-only or unknown objects refuse writes
          stateNext.abort = 1'b1;
        end
      endcase
      if (stateNext.abort) begin
        stateNext.ack = 1'b0;
      end
    end else if (objRead) begin
      // Reads; the answer is registered and valid with the acknowledge
      stateNext.ack    = 1'b1;
      stateNext.rdData = 32'h0000_0000;
      case (objIndex)
        IDX_COMMAND_WORD: stateNext.rdData = {16'h0000, stateReg.cmdWord};
        IDX_STATE_WORD:   stateNext.rdData = {16'h0000, stateWordView};
        IDX_SPEED_REF:    stateNext.rdData = {16'h0000, stateReg.speedRef};
        IDX_RAMP_OUTPUT:  stateNext.rdData = {16'h0000, freqToRpm(rampOutFreq, refPoles)};
        IDX_ACTUAL_SPEED: stateNext.rdData = {16'h0000, freqToRpm(actualFreq, refPoles)};
        IDX_SPEED_LIMITS, IDX_ACCEL, IDX_DECEL: begin
          case (objSub)
            SUB_COUNT: stateNext.rdData = {24'h000000, ENTRY_COUNT};
            SUB_ONE: begin
              stateNext.rdData = (objIndex == IDX_SPEED_LIMITS) ? {16'h0000, stateReg.minRpm} :
                                 (objIndex == IDX_ACCEL) ? {16'h0000, stateReg.accSpeed} :
                                 {16'h0000, stateReg.decSpeed};
            end
            SUB_TWO: begin
              stateNext.rdData = (objIndex == IDX_SPEED_LIMITS) ? {16'h0000, stateReg.maxRpm} :
                                 (objIndex == IDX_ACCEL) ? {16'h0000, stateReg.accTime} :
                                 {16'h0000, stateReg.decTime};
            end
            default: begin
              stateNext.ack   = 1'b0;
              stateNext.abort = 1'b1;
            end
          endcase
        end
        default: begin
          stateNext.ack   = 1'b0;
          stateNext.abort = 1'b1;
        end
      endcase
    end
    // Power-on restore overrides the mirrored parameters
    if (nvLoad) begin
      {stateNext.minRpm, stateNext.maxRpm, stateNext.accSpeed, stateNext.accTime} = nvLoadData[63:0];
      stateNext.minFreq = 32'(rpmToFreq({1'b0, nvLoadData[63:48]}, polePairsSetOne));
      stateNext.maxFreq = 32'(rpmToFreq({1'b0, nvLoadData[47:32]}, polePairsSetOne));
      stateNext.dirty   = 1'b0;
    end
    // Ramp gradients follow any change of either step
    stateNext.accGrad = gradient(stateNext.accSpeed, stateNext.accTime, polePairsSetOne);
    stateNext.decGrad = gradient(stateNext.decSpeed, stateNext.decTime, polePairsSetOne);
    // Save only matters after limit or ramp writes; a write in the same cycle stays dirty
    if (saveCmd && stateReg.dirty) begin
      stateNext.nvStore = 1'b1;
      stateNext.dirty   = stateNext.dirty && objWrite && !stateNext.abort &&
                          (objIndex == IDX_SPEED_LIMITS || objIndex == IDX_ACCEL || objIndex == IDX_DECEL);
    end
  end

  // State register; clock enable low holds everything
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stateReg            <= '0;
      stateReg.minRpm     <= RST_MIN_RPM;
      stateReg.maxRpm     <= RST_MAX_RPM;
      stateReg.accSpeed   <= RST_STEP_RPM;
      stateReg.accTime    <= RST_STEP_TIME;
      stateReg.decSpeed   <= RST_STEP_RPM;
      stateReg.decTime    <= RST_STEP_TIME;
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  // Outputs straight from the state register
  assign objRdData     = stateReg.rdData;
  assign objAck        = stateReg.ack;
  assign objAbort      = stateReg.abort;
  assign stateMachineCmd = stateReg.cmdOut;
  assign rampInputFreq = stateReg.rampInFreq;
  assign minFreqParam  = stateReg.minFreq;
  assign maxFreqParam  = stateReg.maxFreq;
  assign accelCwParam  = stateReg.accGrad;
  assign accelAcwParam = stateReg.accGrad;
  assign decelCwParam  = stateReg.decGrad;
  assign decelAcwParam = stateReg.decGrad;
  assign nvStore       = stateReg.nvStore;
  // Only acceleration pairs with limits fit the store word; deceleration is not saved
  assign nvData        = {stateReg.minRpm, stateReg.maxRpm, stateReg.accSpeed, stateReg.accTime};

  // Checks
  cmd_local_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clkEn && control_source_select != CTRL_SRC_REMOTE) |=> stateMachineCmd == 16'h0000)
    else $error("command passed without remote control source");

  cmd_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
    (stateMachineCmd[15:9] == 7'h00) and
      ((clkEn && !motionConfig) |=> (stateMachineCmd & CMD_MOTION_BITS) == 16'h0))
    else $error("ignored command bits reached the state machine");

  stat_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clkEn && objRead && !objWrite && objIndex == IDX_STATE_WORD && !motionConfig)
      |=> objAck && (objRdData & {16'h0000, STAT_UNUSED_BITS | STAT_MOTION_BITS}) == 32'h0)
    else $error("state word shows unused or motion bits");

  speed_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clkEn && objWrite && objIndex == IDX_SPEED_REF && objSub == SUB_COUNT && !wrSpeedOk) |=> objAbort && !objAck)
    else $error("out of range speed reference accepted");

  count_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clkEn && objRead && !objWrite && objSub == SUB_COUNT &&
     (objIndex == IDX_ACCEL || objIndex == IDX_DECEL || objIndex == IDX_SPEED_LIMITS))
      |=> objRdData == 32'h0000_0002 && objAck)
    else $error("sub-entry zero count wrong");

  limit_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clkEn && objWrite && objIndex == IDX_SPEED_LIMITS && objWrData > RPM_MAX) |=> objAbort && $stable(minFreqParam))
    else $error("limit above range accepted");

  clamp_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    stateReg.speedRef < $signed({1'b0, stateReg.minRpm}) |-> clampedRpm == $signed({1'b0, stateReg.minRpm}))
    else $error("reference below minimum not raised");

  clamp_high_a: assert property (@(posedge clk_sys) disable iff (rst)
    stateReg.minRpm <= stateReg.maxRpm |-> clampedRpm <= $signed({1'b0, stateReg.maxRpm}))
    else $error("reference above maximum not lowered");

  step_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clkEn && objWrite && objIndex == IDX_ACCEL && objSub == SUB_TWO && objWrData == 32'h0) |=> objAbort ##1 !objAbort)
    else $error("zero time step accepted");

  grad_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    accelCwParam == accelAcwParam && decelCwParam == decelAcwParam)
    else $error("direction gradients differ");

  save_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clkEn && saveCmd && stateReg.dirty) |=> nvStore ##1 (!nvStore || $past(saveCmd)))
    else $error("save did not store changed values");

endmodule

`default_nettype wire

// [dv/fieldbus_master.sv]
// Fieldbus master model: issues object reads and writes as one-cycle strobes.
// Assumes the block answers with ack or abort on the edge after the strobe.
`timescale 1ns/100ps
`default_nettype none
module fieldbus_master (
  input  wire logic        clk_sys,    // System clock
  output var  logic        objWrite,   // Write strobe
  output var  logic        objRead,    // Read strobe
  output var  logic [15:0] objIndex,   // Object index
  output var  logic [7:0]  objSub,     // Sub-index
  output var  logic [31:0] objWrData,  // Write data
  input  wire logic [31:0] objRdData,  // Read data
  input  wire logic        objAck,     // Accepted
  input  wire logic        objAbort    // Refused
);
  // Idle bus at time zero
  initial begin
    {objWrite, objRead, objIndex, objSub, objWrData} = '0;
  end
  // One access from a falling edge; idle gap models a slow master
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] d, input int gap, output logic [1:0] rsp,
                        output logic [31:0] rd);
    repeat (gap) @(negedge clk_sys);
    {objWrite, objRead, objIndex, objSub, objWrData} = {wr, !wr, idx, sub, d};
    @(negedge clk_sys);
    // The answer stands for the one cycle after the taking edge; take it here
    rsp = {objAck, objAbort};
    rd  = objRdData;
    // Released lines show the inverse so a stale value never passes
    {objWrite, objRead, objIndex, objSub, objWrData} = {2'b00, ~idx, ~sub, ~d};
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench of the velocity object block, random with fixed seed.
// Assumes the partner master model; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import velocity_objects_pkg::*;
  logic clk_sys = 0, rst, clkEn, motionConfig, saveCmd, nvStore, nvLoad, objWrite, objRead, objAck, objAbort;
  logic [15:0] objIndex, control_source_select, driveState, stateMachineCmd;
  logic [7:0]  objSub, polePairsActive, polePairsSetOne, pp;
  logic [31:0] objWrData, objRdData, minFreqParam, maxFreqParam, accelCwParam, accelAcwParam,
               decelCwParam, decelAcwParam, rdv_d;
  logic signed [31:0] channelRefFreq, rampOutFreq, actualFreq, rampInputFreq;
  logic [63:0] nvData, nvLoadData;
  logic [1:0]  rsp;
  logic signed [15:0] refV;
  logic [15:0] cmd, multiIdx [3];
  int mismatches = 0, tests_run = 0, lo, hi, s, t, accS = 1500, accT = 5, seedVal;
  always #25 clk_sys = ~clk_sys;  // 20 MHz
  velocity_objects u_velocity_objects (.*);
  fieldbus_master u_fieldbus_master (.clk_sys(clk_sys), .objWrite(objWrite), .objRead(objRead),
    .objIndex(objIndex), .objSub(objSub), .objWrData(objWrData), .objRdData(objRdData),
    .objAck(objAck), .objAbort(objAbort));
  // Expected frequency in 0.01 Hz from rpm, truncated toward zero
  function automatic longint rpm2f(input longint rpm, input longint p);
    return rpm * p * FREQ_SCALE / SECS_PER_MIN;
  endfunction
  // Expected rpm readback, low half only
  function automatic logic [31:0] f2rpm(input longint f, input longint p);
    longint r;
    r = f * SECS_PER_MIN / (p * FREQ_SCALE);
    return {16'h0000, r[15:0]};
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Write with expected response {ack, abort}
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic [1:0] er);
    u_fieldbus_master.access(1'b1, idx, sub, d, $urandom_range(0, 2), rsp, rdv_d);
    chk("write response", er, rsp);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    u_fieldbus_master.access(1'b0, idx, sub, 32'h0000_0000, 0, rsp, rdv_d);
    chk("read response", 2'b10, rsp);
    chk("read data", exp, rdv_d);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 400 cycles
  initial begin
    #200_000;
    mismatches++;
    end_sim();
  end
  initial begin
    seedVal = $urandom(90);
    multiIdx = '{IDX_SPEED_LIMITS, IDX_ACCEL, IDX_DECEL};
    {rst, clkEn, control_source_select, motionConfig} = {2'b11, CTRL_SRC_REMOTE, 1'b0};
    {polePairsActive, polePairsSetOne, driveState, saveCmd, nvLoad, nvLoadData} = {16'h0202, 82'h0};
    {channelRefFreq, rampOutFreq, actualFreq} = '0;
    repeat (8) @(negedge clk_sys);
    rst = 0;
    // Sub-entry counts read back and refuse writes
    foreach (multiIdx[i]) begin
      rd(multiIdx[i], SUB_COUNT, {24'h0, ENTRY_COUNT});
      wr(multiIdx[i], SUB_COUNT, 32'h2, 2'b01);
    end
    wr(IDX_STATE_WORD, SUB_COUNT, 32'h1, 2'b01);
    wr(IDX_RAMP_OUTPUT, SUB_COUNT, 32'h1, 2'b01);
    wr(IDX_ACTUAL_SPEED, SUB_COUNT, 32'h1, 2'b01);
    wr(IDX_SPEED_LIMITS, SUB_TWO, 32'h8000, 2'b01);
    wr(IDX_ACCEL, SUB_ONE, 32'h0, 2'b01);
    wr(IDX_DECEL, SUB_TWO, 32'h1_0000, 2'b01);
    for (int n = 0; n < 12; n++) begin
      {polePairsSetOne, polePairsActive} = {8'($urandom_range(1, 8)), 8'($urandom_range(1, 8))};
      motionConfig = n[0];
      pp = motionConfig ? polePairsSetOne : polePairsActive;
      lo = (n == 0) ? 0 : $urandom_range(0, 1000);
      hi = (n == 1) ? 32767 : $urandom_range(2000, 32767);
      wr(IDX_SPEED_LIMITS, SUB_ONE, lo, 2'b10);
      chk("min freq", rpm2f(lo, polePairsSetOne), minFreqParam);
      wr(IDX_SPEED_LIMITS, SUB_TWO, hi, 2'b10);
      chk("max freq", rpm2f(hi, polePairsSetOne), maxFreqParam);
      // Command filter under changing source and configuration
      cmd = 16'($urandom);
      control_source_select = (n % 3 == 2) ? 16'h0002 : CTRL_SRC_REMOTE;
      wr(IDX_COMMAND_WORD, SUB_COUNT, {16'h0000, cmd}, 2'b10);
      // Corner references first; rewritten after each pole change
      refV = (n == 0) ? 16'sh8000 : (n == 1) ? 16'sh7FFF : 16'($urandom);
      channelRefFreq = $urandom_range(0, 2000) - 1000;
      wr(IDX_SPEED_REF, SUB_COUNT, 32'(refV), 2'b10);
      @(negedge clk_sys);
      chk("ramp input", rpm2f(refV < lo ? lo : refV > hi ? hi : refV, pp) + channelRefFreq,
          64'(rampInputFreq));
      chk("command", (control_source_select != CTRL_SRC_REMOTE) ? 16'h0 :
          cmd & CMD_USED_BITS & (motionConfig ? 16'hFFFF : ~CMD_MOTION_BITS), stateMachineCmd);
      {rampOutFreq, actualFreq} = {32'($urandom_range(0, 100000) - 50000), 32'($urandom_range(0, 100000) - 50000)};
      driveState = 16'($urandom);
      rd(IDX_RAMP_OUTPUT, SUB_COUNT, f2rpm(rampOutFreq, pp));
      rd(IDX_ACTUAL_SPEED, SUB_COUNT, f2rpm(actualFreq, pp));
      rd(IDX_STATE_WORD, SUB_COUNT, {16'h0000, driveState & ~STAT_UNUSED_BITS &
         (motionConfig ? 16'hFFFF : ~STAT_MOTION_BITS)});
      // Ramp steps, both boundaries of the time step included
      s = $urandom_range(1, 32767);
      t = (n < 2) ? 1 + n * 65534 : $urandom_range(1, 600);
      wr(n[0] ? IDX_DECEL : IDX_ACCEL, SUB_ONE, s, 2'b10);
      wr(n[0] ? IDX_DECEL : IDX_ACCEL, SUB_TWO, t, 2'b10);
      if (!n[0]) {accS, accT} = {s, t};
      @(negedge clk_sys);
      chk("cw gradient", rpm2f(s, polePairsSetOne) / t, n[0] ? decelCwParam : accelCwParam);
      chk("acw gradient", rpm2f(s, polePairsSetOne) / t, n[0] ? decelAcwParam : accelAcwParam);
      saveCmd = 1;
      @(negedge clk_sys);
      chk("store pulse", 1'b1, nvStore);
      chk("store data", {16'(lo), 16'(hi), 16'(accS), 16'(accT)}, nvData);
      saveCmd = 0;
      @(negedge clk_sys);
    end
    // Power-on restore overrides limits and acceleration steps
    nvLoadData = {16'd10, 16'd20000, 16'd100, 16'd2};
    nvLoad = 1;
    @(negedge clk_sys);
    nvLoad = 0;
    @(negedge clk_sys);
    chk("restored min freq", rpm2f(10, polePairsSetOne), minFreqParam);
    @(negedge clk_sys);
    chk("restored gradient", rpm2f(100, polePairsSetOne) / 2, accelCwParam);
    saveCmd = 1;
    @(negedge clk_sys);
    chk("no store when clean", 1'b0, nvStore);
    saveCmd = 0;
    // Clock enable low freezes state: a write is neither answered nor stored
    clkEn = 0;
    wr(IDX_SPEED_LIMITS, SUB_ONE, 32'h0000_0064, 2'b00);
    chk("frozen min freq", rpm2f(10, polePairsSetOne), minFreqParam);
    clkEn = 1;
    end_sim();
  end
endmodule
`default_nettype wire
